// [hacc_pkg.sv]
// hacc_pkg: constants for the hot alert and adc control register bank
package hacc_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] HOT_ALERT_SOURCE_ENABLES_OFS = 8'h38;
	localparam logic [7:0] DISCHARGE_TRIP_THRESHOLD_OFS = 8'h39;
	localparam logic [7:0] ADC_CHANNEL_ENABLES_OFS = 8'h3A;
	localparam logic [7:0] ADC_CONVERSION_CONTROL_OFS = 8'h3B;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] HOT_ALERT_SOURCE_ENABLES_RST = 8'hA0;
	localparam logic [7:0] DISCHARGE_TRIP_THRESHOLD_RST = 8'h81;
	localparam logic [7:0] ADC_CHANNEL_ENABLES_RST = 8'h00;
	localparam logic [7:0] ADC_CONVERSION_CONTROL_RST = 8'h20;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int SRC_INPUT_DROOP = 7;
	localparam int SRC_COMPARATOR = 6;
	localparam int SRC_CRITICAL_CURRENT = 5;
	localparam int SRC_NORMAL_CURRENT = 4;
	localparam int SRC_DISCHARGE_CURRENT = 3;
	localparam int SRC_SYSTEM_VOLTAGE = 2;
	localparam int SRC_BATTERY_REMOVAL = 1;
	localparam int SRC_ADAPTER_REMOVAL = 0;
	localparam int LEVEL_MSB = 7;
	localparam int LEVEL_LSB = 2;
	localparam int FILTER_MSB = 1;
	localparam int FILTER_LSB = 0;
	localparam int REPEAT_MODE_BIT = 7;
	localparam int START_BIT = 6;
	localparam int RESERVED_MSB = 5;

	// ---------------------------------------------------------------
	// threshold scaling and filter codes
	// ---------------------------------------------------------------
	localparam logic [15:0] LEVEL_STEP_MA = 16'h0200;
	localparam logic [15:0] LEVEL_OFFSET_MA = 16'h0080;
	localparam logic [5:0] LEVEL_ALWAYS_TRIP = 6'h00;
	localparam logic [1:0] FILTER_SEL_1P6MS = 2'h0;
	localparam logic [1:0] FILTER_SEL_100US = 2'h1;
	localparam logic [1:0] FILTER_SEL_6MS = 2'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int FILTER_1P6MS_NS = 1_600_000;
	localparam int FILTER_100US_NS = 100_000;
	localparam int FILTER_6MS_NS = 6_000_000;
	localparam int REPEAT_PERIOD_NS = 1_000_000_000;
	localparam int FILTER_1P6MS_CYC = (FILTER_1P6MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_100US_CYC = (FILTER_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_6MS_CYC = (FILTER_6MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPEAT_PERIOD_CYC = (REPEAT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	// conversion sequencer states
	typedef enum logic [2:0] {
		HACC_IDLE = 3'b001,
		HACC_BUSY = 3'b010,
		HACC_WAIT = 3'b100
	} hacc_conv_state_t;
endpackage

// [hacc_filter.sv]
// hacc_filter: deglitch filter holding off a trip until it persists
`timescale 1ns/10ps
module hacc_filter (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// raw trip and required persistence
	input wire logic raw_trip,
	input wire logic [hacc_pkg::CNT_W-1:0] hold_cycles,
	// filtered trip
	output logic trip_out
);
	logic [hacc_pkg::CNT_W-1:0] cnt_ff;

	// count persistence; a single low cycle restarts the wait
	always_ff @(posedge clk) begin
		if (srst || !raw_trip) begin
			cnt_ff <= '0;
		end else if (cnt_ff < hold_cycles) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// trip drops at once, rises only after the full hold
	always_ff @(posedge clk) begin
		if (srst) begin
			trip_out <= 1'b0;
		end else begin
			trip_out <= raw_trip && (cnt_ff + 1'b1 >= hold_cycles);
		end
	end
endmodule

// [hacc_top.sv]
// hacc_top: hot alert source gating, discharge trip and adc conversion control
//
// Behaviour
// - each of the eight trip sources has its own enable and a disabled source never pulls the alert.
// - after reset only input droop and critical current may raise the alert.
// - a six-bit discharge level in bits 7 to 2 spans 0 to 32256 mA in 512 mA steps and resets to code 100000.
// - the discharge comparison adds a fixed 128 mA to the programmed level.
// - a level code of all zeros trips continuously whenever the discharge source is enabled.
// - the discharge trip is deglitched by 1.6 ms, 100 us or 6 ms per a two-bit select, code 11 undefined.
// - eight adc channel enables, all reset off, cover comparator input down to battery voltage.
// - a mode bit picks one pass (0) or a pass repeated every second (1) and resets to zero.
// - writing one to start while idle launches a pass and in one-pass mode the bit self-clears when done.
`timescale 1ns/10ps
module hacc_top #(
	parameter int FILTER_1P6MS_CYCLES = hacc_pkg::FILTER_1P6MS_CYC,
	parameter int FILTER_6MS_CYCLES = hacc_pkg::FILTER_6MS_CYC,
	parameter int REPEAT_PERIOD_CYCLES = hacc_pkg::REPEAT_PERIOD_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// decoded register access from the management bus
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// trip conditions, bit order as the source enable register
	input wire logic [7:0] trip_conditions,
	input wire logic [15:0] discharge_current_ma,
	// alert toward the processor
	output logic hot_alert_n,
	// converter control
	output logic [7:0] meas_channel_en,
	output logic conv_launch,
	input wire logic conv_pass_done,
	output logic conv_busy
);
	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [7:0] hot_alert_source_enables_ff;
	logic [7:0] discharge_trip_threshold_ff;
	logic [7:0] adc_channel_enables_ff;
	logic conversion_repeat_mode_ff;
	logic start_ff;
	logic [5:0] reserved_ff;
	logic [7:0] reg_rdata_ff;
	logic hot_alert_n_ff;
	logic launch_ff;
	hacc_pkg::hacc_conv_state_t state_ff;
	hacc_pkg::hacc_conv_state_t nxt_state;
	logic [hacc_pkg::CNT_W-1:0] period_cnt_ff;

	logic wr_src;
	logic wr_level;
	logic wr_chan;
	logic wr_ctrl;
	logic [5:0] discharge_trip_level;
	logic [1:0] discharge_trip_filter;
	logic [15:0] level_ma;
	logic discharge_raw;
	logic discharge_filtered;
	logic [hacc_pkg::CNT_W-1:0] filter_cycles;
	logic [7:0] gated_trips;
	logic pass_end;
	logic start_write_one;
	logic start_write_zero;

	// address decode for writes; a write lands one edge after its strobe
	// and a read in the same cycle still returns the old contents
	assign wr_src = reg_wr && (reg_addr == hacc_pkg::HOT_ALERT_SOURCE_ENABLES_OFS);
	assign wr_level = reg_wr && (reg_addr == hacc_pkg::DISCHARGE_TRIP_THRESHOLD_OFS);
	assign wr_chan = reg_wr && (reg_addr == hacc_pkg::ADC_CHANNEL_ENABLES_OFS);
	assign wr_ctrl = reg_wr && (reg_addr == hacc_pkg::ADC_CONVERSION_CONTROL_OFS);
	assign start_write_one = wr_ctrl && reg_wdata[hacc_pkg::START_BIT];
	assign start_write_zero = wr_ctrl && !reg_wdata[hacc_pkg::START_BIT];

	// ---------------------------------------------------------------
	// alert source enables
	// ---------------------------------------------------------------
	// reset to droop and critical
	always_ff @(posedge clk) begin
		if (srst) begin
			hot_alert_source_enables_ff <= hacc_pkg::HOT_ALERT_SOURCE_ENABLES_RST;
		end else if (wr_src) begin
			hot_alert_source_enables_ff <= reg_wdata;
		end
	end

	// ---------------------------------------------------------------
	// discharge level and filter select
	// ---------------------------------------------------------------
	// level field storage
	always_ff @(posedge clk) begin
		if (srst) begin
			discharge_trip_threshold_ff <= hacc_pkg::DISCHARGE_TRIP_THRESHOLD_RST;
		end else if (wr_level) begin
			discharge_trip_threshold_ff <= reg_wdata;
		end
	end

	assign discharge_trip_level = discharge_trip_threshold_ff[hacc_pkg::LEVEL_MSB:hacc_pkg::LEVEL_LSB];
	assign discharge_trip_filter = discharge_trip_threshold_ff[hacc_pkg::FILTER_MSB:hacc_pkg::FILTER_LSB];

	assign level_ma = 16'(discharge_trip_level * hacc_pkg::LEVEL_STEP_MA) + hacc_pkg::LEVEL_OFFSET_MA;

	assign discharge_raw = (discharge_trip_level == hacc_pkg::LEVEL_ALWAYS_TRIP) ||
		(discharge_current_ma > level_ma);

	// filter select; undefined code falls back to the reset time
	always_comb begin
		case (discharge_trip_filter)
			hacc_pkg::FILTER_SEL_1P6MS: filter_cycles = hacc_pkg::CNT_W'(FILTER_1P6MS_CYCLES);
			hacc_pkg::FILTER_SEL_100US: filter_cycles = hacc_pkg::CNT_W'(hacc_pkg::FILTER_100US_CYC);
			hacc_pkg::FILTER_SEL_6MS: filter_cycles = hacc_pkg::CNT_W'(FILTER_6MS_CYCLES);
			default: filter_cycles = hacc_pkg::CNT_W'(hacc_pkg::FILTER_100US_CYC);
		endcase
	end

	// any low cycle restarts the count: this rejects chatter near the
	// threshold at the cost of a late alert when the current hovers there
	// deglitch only the discharge comparison; other sources arrive filtered
	hacc_filter u_discharge_filter (
		.clk(clk),
		.srst(srst),
		.raw_trip(discharge_raw),
		.hold_cycles(filter_cycles),
		.trip_out(discharge_filtered)
	);

	// ---------------------------------------------------------------
	// alert gating
	// ---------------------------------------------------------------
	// trip_conditions bit 3 is not used; the discharge trip is built here
	// per-source gating
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_src
			if (gi == hacc_pkg::SRC_DISCHARGE_CURRENT) begin : g_dis
				assign gated_trips[gi] = hot_alert_source_enables_ff[gi] && discharge_filtered;
			end else begin : g_oth
				assign gated_trips[gi] = hot_alert_source_enables_ff[gi] && trip_conditions[gi];
			end
		end
	endgenerate

	// registered alert, released high through reset; kept active low in
	// the flop so the pin comes straight from a register with no glitch
	always_ff @(posedge clk) begin
		if (srst) begin
			hot_alert_n_ff <= 1'b1;
		end else begin
			hot_alert_n_ff <= ~(|gated_trips);
		end
	end

	assign hot_alert_n = hot_alert_n_ff;

	// ---------------------------------------------------------------
	// adc channel enables
	// ---------------------------------------------------------------
	// channel enables reset off
	always_ff @(posedge clk) begin
		if (srst) begin
			adc_channel_enables_ff <= hacc_pkg::ADC_CHANNEL_ENABLES_RST;
		end else if (wr_chan) begin
			adc_channel_enables_ff <= reg_wdata;
		end
	end

	assign meas_channel_en = adc_channel_enables_ff;

	// ---------------------------------------------------------------
	// conversion control register
	// ---------------------------------------------------------------
	// mode bit storage
	always_ff @(posedge clk) begin
		if (srst) begin
			conversion_repeat_mode_ff <= hacc_pkg::ADC_CONVERSION_CONTROL_RST[hacc_pkg::REPEAT_MODE_BIT];
		end else if (wr_ctrl) begin
			conversion_repeat_mode_ff <= reg_wdata[hacc_pkg::REPEAT_MODE_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reserved_ff <= hacc_pkg::ADC_CONVERSION_CONTROL_RST[hacc_pkg::RESERVED_MSB:0];
		end else if (wr_ctrl) begin
			reserved_ff <= reg_wdata[hacc_pkg::RESERVED_MSB:0];
		end
	end

	// single pass completes only in one-pass mode
	assign pass_end = (state_ff == hacc_pkg::HACC_BUSY) && conv_pass_done && !conversion_repeat_mode_ff;

	// a host write and a pass end in one cycle: the host write wins the start bit, but the
	// sequencer still returns to idle, so a restart issued as the pass finishes launches no pass
	// start set by host, self-clear on pass end; a fresh write of one wins
	always_ff @(posedge clk) begin
		if (srst) begin
			start_ff <= hacc_pkg::ADC_CONVERSION_CONTROL_RST[hacc_pkg::START_BIT];
		end else if (wr_ctrl) begin
			start_ff <= reg_wdata[hacc_pkg::START_BIT];
		end else if (pass_end) begin
			start_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// conversion sequencer
	// ---------------------------------------------------------------
	// a completion seen outside busy is ignored; the host should let an
	// aborted pass drain before restarting, or its late answer ends the next
	// next state; a write of zero to start aborts from busy or wait
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			hacc_pkg::HACC_IDLE: begin
				if (start_write_one) begin
					nxt_state = hacc_pkg::HACC_BUSY;
				end
			end
			hacc_pkg::HACC_BUSY: begin
				if (start_write_zero) begin
					nxt_state = hacc_pkg::HACC_IDLE;
				end else if (conv_pass_done) begin
					nxt_state = conversion_repeat_mode_ff ? hacc_pkg::HACC_WAIT : hacc_pkg::HACC_IDLE;
				end
			end
			hacc_pkg::HACC_WAIT: begin
				if (start_write_zero) begin
					nxt_state = hacc_pkg::HACC_IDLE;
				end else if (period_cnt_ff + 1'b1 >= hacc_pkg::CNT_W'(REPEAT_PERIOD_CYCLES)) begin
					nxt_state = hacc_pkg::HACC_BUSY;
				end
			end
			default: nxt_state = hacc_pkg::HACC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= hacc_pkg::HACC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// the counter saturates, so a long stall can never wrap into an early
	// relaunch; it only matters while the sequencer waits
	// repeat period, counted from each pass launch
	always_ff @(posedge clk) begin
		if (srst || launch_ff) begin
			period_cnt_ff <= '0;
		end else if (period_cnt_ff != '1) begin
			period_cnt_ff <= period_cnt_ff + 1'b1;
		end
	end

	// one pulse per pass; the converter never has to find an edge in a level
	// launch pulse on every entry to busy
	always_ff @(posedge clk) begin
		if (srst) begin
			launch_ff <= 1'b0;
		end else begin
			launch_ff <= (nxt_state == hacc_pkg::HACC_BUSY) && (state_ff != hacc_pkg::HACC_BUSY);
		end
	end

	// busy is a state decode, usable by the converter as a handshake level
	assign conv_launch = launch_ff;
	assign conv_busy = (state_ff == hacc_pkg::HACC_BUSY);

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// reserved control bits read back as last written, so the host can
	// read, modify and write the control register without disturbing them
	// read data registered; unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata_ff <= hacc_pkg::UNMAPPED_READ_VALUE;
		end else if (reg_rd) begin
			case (reg_addr)
				hacc_pkg::HOT_ALERT_SOURCE_ENABLES_OFS: reg_rdata_ff <= hot_alert_source_enables_ff;
				hacc_pkg::DISCHARGE_TRIP_THRESHOLD_OFS: reg_rdata_ff <= discharge_trip_threshold_ff;
				hacc_pkg::ADC_CHANNEL_ENABLES_OFS: reg_rdata_ff <= adc_channel_enables_ff;
				hacc_pkg::ADC_CONVERSION_CONTROL_OFS: reg_rdata_ff <= {conversion_repeat_mode_ff, start_ff, reserved_ff};
				default: reg_rdata_ff <= hacc_pkg::UNMAPPED_READ_VALUE;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_ff;
endmodule

// [hacc_top_properties.sv]
// hacc_top_properties: concurrent checks on the hacc_top ports
`timescale 1ns/10ps
module hacc_top_properties (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// trips and alert
	input wire logic [7:0] trip_conditions,
	input wire logic [15:0] discharge_current_ma,
	input wire logic hot_alert_n,
	// converter control
	input wire logic [7:0] meas_channel_en,
	input wire logic conv_launch,
	input wire logic conv_pass_done,
	input wire logic conv_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic [7:0] en_ff;
	// shadow of the source enables, so gating can be judged without the bodies
	always_ff @(posedge clk) begin
		if (srst) begin
			en_ff <= 8'hA0;
		end else if (reg_wr && reg_addr == 8'h38) begin
			en_ff <= reg_wdata;
		end
	end
	// a launch the host did not ask for never follows another within eight cycles
	sequence s_quiet_gap;
		(!conv_launch || $past(reg_wr && reg_addr == 8'h3B && reg_wdata[6])) [*8];
	endsequence
	// a pass in flight with no completion and no host write
	sequence s_pass_pending;
		conv_busy && !conv_pass_done && !reg_wr;
	endsequence
	property p_launch_busy;
		conv_launch |-> conv_busy;
	endproperty
	property p_launch_gap;
		conv_launch |=> s_quiet_gap;
	endproperty
	property p_busy_cause;
		$rose(conv_busy) |-> conv_launch;
	endproperty
	property p_busy_holds;
		s_pass_pending |=> conv_busy;
	endproperty
	property p_done_ends;
		conv_busy && conv_pass_done && !reg_wr |=> !conv_busy;
	endproperty
	property p_meas_write;
		reg_wr && reg_addr == 8'h3A |=> meas_channel_en == $past(reg_wdata);
	endproperty
	// read of the channel enables returns what drives the converter
	property p_meas_readback;
		reg_rd && !reg_wr && reg_addr == 8'h3A |=> reg_rdata == meas_channel_en;
	endproperty
	// discharge bit excluded: its trip is computed inside
	property p_alert_quiet;
		(trip_conditions & en_ff & 8'hF7) == 8'h00 && !en_ff[3] |=> hot_alert_n;
	endproperty
	property p_alert_raise;
		(trip_conditions & en_ff & 8'hF7) != 8'h00 |=> !hot_alert_n;
	endproperty
	a_launch_busy: assert property (p_launch_busy) else $error("launch without busy");
	a_launch_gap: assert property (p_launch_gap) else $error("launch repeated too soon");
	a_busy_cause: assert property (p_busy_cause) else $error("busy rose without launch");
	a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early");
	a_done_ends: assert property (p_done_ends) else $error("busy stayed after done");
	a_meas_write: assert property (p_meas_write) else $error("channel enables not updated");
	a_meas_readback: assert property (p_meas_readback) else $error("channel enables read back wrong");
	a_alert_quiet: assert property (p_alert_quiet) else $error("alert from disabled source");
	a_alert_raise: assert property (p_alert_raise) else $error("enabled trip gave no alert");
endmodule

bind hacc_top hacc_top_properties chk_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trip_conditions(trip_conditions),
	.discharge_current_ma(discharge_current_ma), .hot_alert_n(hot_alert_n), .meas_channel_en(meas_channel_en),
	.conv_launch(conv_launch), .conv_pass_done(conv_pass_done), .conv_busy(conv_busy));

// [hacc_conv_model.sv]
// hacc_conv_model: converter stand-in answering each launched pass
`timescale 1ns/10ps
module hacc_conv_model (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// launch in, pass length, completion out
	input wire logic conv_launch,
	input wire logic [7:0] lag,
	output logic conv_pass_done
);
	logic [7:0] cnt_ff;
	logic run_ff;
	// a pass takes lag plus two cycles, never instant
	always_ff @(posedge clk) begin
		if (srst) begin
			run_ff <= 1'b0;
			cnt_ff <= 8'h00;
			conv_pass_done <= 1'b0;
		end else begin
			conv_pass_done <= run_ff && cnt_ff == 8'h00;
			if (conv_launch) begin
				run_ff <= 1'b1;
				cnt_ff <= lag;
			end else if (run_ff && cnt_ff == 8'h00) begin
				run_ff <= 1'b0;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule

// [tb.sv]
// tb: register bank bench with converter stand-in
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] trip_conditions = 8'h00;
	logic [7:0] lag = 8'h00;
	logic [15:0] discharge_current_ma = 16'h0000;
	logic [7:0] reg_rdata, meas_channel_en;
	logic hot_alert_n, conv_launch, conv_pass_done, conv_busy;
	int fails = 0;
	int n_tests = 0;
	int launches = 0;
	int cycles = 0;
	// level register value, current, trips, filter cycles (00=20, 01=1000, 10=40, 11=1000)
	logic [7:0] lv [8] = '{8'h04, 8'h04, 8'h05, 8'h06, 8'hFC, 8'hFC, 8'h02, 8'h07};
	logic [15:0] cur [8] = '{16'h0280, 16'h0281, 16'h0281, 16'h0281, 16'h7E80, 16'h7E81, 16'h0000, 16'h0281};
	logic trp [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	int nf [8] = '{20, 20, 1000, 40, 20, 20, 40, 1000};

	always #50 clk = ~clk;

	// shortened filter and repeat counts keep the run brief
	hacc_top #(.FILTER_1P6MS_CYCLES(20), .FILTER_6MS_CYCLES(40), .REPEAT_PERIOD_CYCLES(50)) dut_u (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .trip_conditions(trip_conditions), .discharge_current_ma(discharge_current_ma),
		.hot_alert_n(hot_alert_n), .meas_channel_en(meas_channel_en), .conv_launch(conv_launch),
		.conv_pass_done(conv_pass_done), .conv_busy(conv_busy));
	hacc_conv_model conv_u (.clk(clk), .srst(srst), .conv_launch(conv_launch), .lag(lag),
		.conv_pass_done(conv_pass_done));

	// launch counter and hang guard
	always @(posedge clk) begin
		cycles++;
		if (conv_launch === 1'b1) begin
			launches++;
		end
		if (cycles == 5000) begin
			fails++;
			final_report();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request set after a falling edge, held across the sampling rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic alert_is(input logic e);
		chk({15'h0000, hot_alert_n}, {15'h0000, e});
	endtask
	task automatic final_report;
		if (fails == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		cyc(12);
		srst = 1'b0;
		rd(8'h38, 8'hA0);
		rd(8'h39, 8'h81);
		rd(8'h3A, 8'h00);
		rd(8'h3B, 8'h20);
		rd(8'h3C, 8'h00);
		// only droop and critical current alert out of reset
		trip_conditions = 8'h5F;
		cyc(3);
		alert_is(1'b1);
		trip_conditions = 8'h20;
		cyc(3);
		alert_is(1'b0);
		trip_conditions = 8'h80;
		cyc(3);
		alert_is(1'b0);
		// each source except discharge alone, with every other source tripping
		for (int i = 0; i < 8; i++) begin
			if (i == 3) continue;
			trip_conditions = ~(8'h01 << i);
			wr(8'h38, 8'h01 << i);
			cyc(3);
			alert_is(1'b1);
			trip_conditions = 8'h01 << i;
			cyc(3);
			alert_is(1'b0);
			rd(8'h38, 8'h01 << i);
		end
		// discharge level boundaries and filter lengths
		trip_conditions = 8'h00;
		wr(8'h38, 8'h08);
		for (int k = 0; k < 8; k++) begin
			wr(8'h39, lv[k]);
			discharge_current_ma = cur[k];
			cyc(nf[k] - 3);
			alert_is(1'b1);
			cyc(6);
			alert_is(!trp[k]);
			rd(8'h39, lv[k]);
			discharge_current_ma = 16'h0000;
			wr(8'h39, 8'h81);
			cyc(5);
			alert_is(1'b1);
		end
		// level zero with the discharge source off stays quiet
		wr(8'h39, 8'h02);
		wr(8'h38, 8'h00);
		cyc(45);
		alert_is(1'b1);
		wr(8'h3A, 8'hA5);
		cyc(2);
		chk({8'h00, meas_channel_en}, 16'h00A5);
		rd(8'h3A, 8'hA5);
		// single pass, fast converter; reserved bits written back as read
		wr(8'h3B, 8'h60);
		cyc(20);
		rd(8'h3B, 8'h20);
		cyc(60);
		chk(16'(launches), 16'h0001);
		// repeat mode, slow converter, then stop
		lag = 8'h09;
		wr(8'h3B, 8'hE0);
		cyc(105);
		chk(16'(launches), 16'h0004);
		rd(8'h3B, 8'hE0);
		wr(8'h3B, 8'hA0);
		cyc(60);
		chk(16'(launches), 16'h0004);
		chk({15'h0000, conv_busy}, 16'h0000);
		final_report();
	end
endmodule
